// File: design/eif_defs.vh
// Constants for the external interrupt flag and enable block
`ifndef EIF_DEFS_VH
`define EIF_DEFS_VH

// Register indices on the special-function register port
`define EIF_ADDR_W 8
`define EIF_DATA_W 8
`define EIF_OFS_FLAG_LOW 8'h04
`define EIF_OFS_ENABLE_LOW 8'h05
`define EIF_OFS_FLAG_HIGH 8'h06
`define EIF_OFS_ENABLE_HIGH 8'h07
`define EIF_OFS_EVT_STATUS 8'h10
`define EIF_OFS_EVT_MASK 8'h11
`define EIF_OFS_PIN_LOW 8'h12
`define EIF_OFS_PIN_HIGH 8'h13
`define EIF_OFS_REQ_LOW 8'h14
`define EIF_OFS_REQ_HIGH 8'h15

// Source counts
`define EIF_NSRC_LOW 8
`define EIF_NSRC_HIGH 4
`define EIF_NSRC 12

// Reset values
`define EIF_RST_ENABLE_LOW 8'h00
`define EIF_RST_ENABLE_HIGH 4'h0
`define EIF_RST_FLAG_LOW 8'h00
`define EIF_RST_FLAG_HIGH 4'h0
`define EIF_RST_EVT 5'h00
`define EIF_RST_DATA 8'h00

// Event status layout
`define EIF_EVT_W 5
`define EIF_EVT_EDGE_LOW 0
`define EIF_EVT_EDGE_HIGH 1
`define EIF_EVT_OVR_LOW 2
`define EIF_EVT_OVR_HIGH 3
`define EIF_EVT_REQ_RISE 4

// Synchroniser fill count after reset release
`define EIF_PRIME_CNT 2'h3

`endif

// File: design/eif_sync_edge.v
// Pin synchroniser and polarity-selected edge detector
`timescale 1ns/100ps
module eif_sync_edge
#(
	parameter W = 12
)
(
	input wire mclk,
	input wire rst,
	input wire [W-1:0] pin,
	input wire [W-1:0] pol_fall,
	output wire [W-1:0] level,
	output wire [W-1:0] edge_hit
);
`include "eif_defs.vh"

reg [W-1:0] meta_r;
reg [W-1:0] sync_r;
reg [W-1:0] prev_r;
reg [1:0] prime_r;
wire primed;

// First stage feeds only the second stage
always @(posedge mclk or posedge rst)
begin
	if (rst)
	begin
		meta_r <= {W{1'b0}};
		sync_r <= {W{1'b0}};
		prev_r <= {W{1'b0}};
		prime_r <= 2'h0;
	end
	else
	begin
		meta_r <= pin;
		sync_r <= meta_r;
		prev_r <= sync_r;
		if (!primed)
			prime_r <= prime_r + 2'h1;
	end
end

// No edges until the pipeline holds real pin samples
assign primed = (prime_r == `EIF_PRIME_CNT);
assign level = sync_r;
// Falling edge when select is 1, rising when 0
assign edge_hit = {W{primed}} & ((pol_fall & prev_r & ~sync_r) |
	(~pol_fall & ~prev_r & sync_r)); // RULE_04 RULE_10

endmodule // eif_sync_edge

// File: design/eif_flag_reg.v
// Sticky edge flag register, software written, hardware set
`timescale 1ns/100ps
module eif_flag_reg
#(
	parameter W = 8
)
(
	input wire mclk,
	input wire rst,
	input wire wr_en,
	input wire [W-1:0] wr_data,
	input wire [W-1:0] set,
	output reg [W-1:0] flag_r
);

reg [W-1:0] flag_nxt;

// A hardware set in the write cycle wins over a written 0
always @*
begin
	flag_nxt = flag_r;
	if (wr_en)
		flag_nxt = wr_data; // RULE_06
	flag_nxt = flag_nxt | set; // RULE_10
end

always @(posedge mclk or posedge rst)
begin
	if (rst)
		flag_r <= {W{1'b0}}; // RULE_03
	else
		flag_r <= flag_nxt;
end

endmodule // eif_flag_reg

// File: design/eif_top.v
// External interrupt enable and edge flag logic with register port
// Function
// (RULE_01) Low enable register resets to zero
// (RULE_02) Enable bit 1 enables source 7..0
// (RULE_03) High flag register resets to zero
// (RULE_04) Flag set on selected edge of pin
// (RULE_05) Request CPU when flag and enable set
// (RULE_06) Flag holds until software write or reset
// (RULE_07) Software clears flag before handler returns
// (RULE_08) High enable register, index 07h, resets zero
// (RULE_09) Low flags at index 04h, same behaviour
// (RULE_10) Synchronise pins, edge sets flag one cycle
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/100ps
`include "eif_defs.vh"
module eif_top
#(
	parameter NLOW = `EIF_NSRC_LOW,
	parameter NHIGH = `EIF_NSRC_HIGH
)
(
	input wire mclk,
	input wire rst,
	input wire [NLOW+NHIGH-1:0] int_pin,
	input wire [NLOW+NHIGH-1:0] edge_polarity_select,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata_r,
	output reg cpu_int_req_r,
	output reg [NLOW+NHIGH-1:0] src_req_r,
	output reg irq_r
);

localparam N = NLOW + NHIGH;

// Register strobes
wire wr_flag_low;
wire wr_enable_low;
wire wr_flag_high;
wire wr_enable_high;
wire wr_evt_status;
wire wr_evt_mask;

// Register contents
reg [NLOW-1:0] ext_int_enable_low_r;
reg [NLOW-1:0] ext_int_enable_low_nxt;
reg [NHIGH-1:0] ext_int_enable_high_r;
reg [NHIGH-1:0] ext_int_enable_high_nxt;
wire [NLOW-1:0] ext_int_flag_low;
wire [NHIGH-1:0] edge_flag_bits_high;
reg [`EIF_EVT_W-1:0] evt_status_r;
reg [`EIF_EVT_W-1:0] evt_status_nxt;
reg [`EIF_EVT_W-1:0] evt_mask_r;
reg [`EIF_EVT_W-1:0] evt_mask_nxt;

// Pin side
wire [N-1:0] pin_level;
wire [N-1:0] edge_hit;
wire [NLOW-1:0] edge_low;
wire [NHIGH-1:0] edge_high;

// Request side
wire [N-1:0] flags_all;
wire [N-1:0] enables_all;
wire [N-1:0] req_vec;
wire cpu_req_nxt;
wire [`EIF_EVT_W-1:0] evt_set;
reg [7:0] rdata_nxt;

// Narrow views of the write data and byte views for reads
wire [NLOW-1:0] wdata_low;
wire [NHIGH-1:0] wdata_high;
wire [`EIF_EVT_W-1:0] wdata_evt;
reg [7:0] lane_flag_low;
reg [7:0] lane_en_low;
reg [7:0] lane_flag_high;
reg [7:0] lane_en_high;
reg [7:0] lane_evt_status;
reg [7:0] lane_evt_mask;
reg [7:0] lane_pin_low;
reg [7:0] lane_pin_high;
reg [7:0] lane_req_low;
reg [7:0] lane_req_high;

// Decodes one register index against the write strobe
function wr_hit;
	input [7:0] addr;
	input [7:0] ofs;
	input strobe;
	begin
		wr_hit = strobe && (addr == ofs);
	end
endfunction

// Zero-extends a narrow field into a byte lane
function [7:0] pad8;
	input [7:0] val;
	input integer width;
	integer i;
	begin
		pad8 = 8'h00;
		for (i = 0; i < 8; i = i + 1)
			if (i < width)
				pad8[i] = val[i];
	end
endfunction

// Write-one-to-clear, with a same-cycle set taking priority
function [`EIF_EVT_W-1:0] w1c;
	input [`EIF_EVT_W-1:0] cur;
	input [`EIF_EVT_W-1:0] set;
	input wr;
	input [`EIF_EVT_W-1:0] wdata;
	begin
		w1c = cur;
		if (wr)
			w1c = cur & ~wdata;
		w1c = w1c | set;
	end
endfunction

assign wr_flag_low = wr_hit(reg_addr, `EIF_OFS_FLAG_LOW, reg_wr);
assign wr_enable_low = wr_hit(reg_addr, `EIF_OFS_ENABLE_LOW, reg_wr);
assign wr_flag_high = wr_hit(reg_addr, `EIF_OFS_FLAG_HIGH, reg_wr);
assign wr_enable_high = wr_hit(reg_addr, `EIF_OFS_ENABLE_HIGH, reg_wr);
assign wr_evt_status = wr_hit(reg_addr, `EIF_OFS_EVT_STATUS, reg_wr);
assign wr_evt_mask = wr_hit(reg_addr, `EIF_OFS_EVT_MASK, reg_wr);

assign wdata_low = reg_wdata[NLOW-1:0];
assign wdata_high = reg_wdata[NHIGH-1:0];
assign wdata_evt = reg_wdata[`EIF_EVT_W-1:0];

// Pin synchronisers and edge detection for all sources
eif_sync_edge
#(
	.W(N)
)
u_sync
(
	.mclk(mclk),
	.rst(rst),
	.pin(int_pin),
	.pol_fall(edge_polarity_select),
	.level(pin_level),
	.edge_hit(edge_hit)
);

assign edge_low = edge_hit[NLOW-1:0];
assign edge_high = edge_hit[N-1:NLOW];

// Flags for sources 7..0
eif_flag_reg
#(
	.W(NLOW)
)
u_flag_low
(
	.mclk(mclk),
	.rst(rst),
	.wr_en(wr_flag_low),
	.wr_data(wdata_low),
	.set(edge_low),
	.flag_r(ext_int_flag_low)
); // RULE_09

// Flags for sources 11..8; upper bits of that byte are reserved
eif_flag_reg
#(
	.W(NHIGH)
)
u_flag_high
(
	.mclk(mclk),
	.rst(rst),
	.wr_en(wr_flag_high),
	.wr_data(wdata_high),
	.set(edge_high),
	.flag_r(edge_flag_bits_high)
); // RULE_04

// Enable registers
always @*
begin
	ext_int_enable_low_nxt = ext_int_enable_low_r;
	ext_int_enable_high_nxt = ext_int_enable_high_r;
	if (wr_enable_low)
		ext_int_enable_low_nxt = wdata_low; // RULE_02
	if (wr_enable_high)
		ext_int_enable_high_nxt = wdata_high; // RULE_08
end

always @(posedge mclk or posedge rst)
begin
	if (rst)
		ext_int_enable_low_r <= `EIF_RST_ENABLE_LOW; // RULE_01
	else
		ext_int_enable_low_r <= ext_int_enable_low_nxt;
end

// Enables for sources 11..8; upper bits of that byte are reserved
always @(posedge mclk or posedge rst)
begin
	if (rst)
		ext_int_enable_high_r <= `EIF_RST_ENABLE_HIGH; // RULE_08
	else
		ext_int_enable_high_r <= ext_int_enable_high_nxt;
end

// Request to the CPU: a flag written to 1 by software counts too.
// The request stays up while the flag and its enable stay set, so a handler that
// returns without clearing its flag is entered again.
assign flags_all = {edge_flag_bits_high, ext_int_flag_low};
assign enables_all = {ext_int_enable_high_r, ext_int_enable_low_r};
assign req_vec = flags_all & enables_all; // RULE_05 RULE_02
assign cpu_req_nxt = |req_vec; // RULE_05 RULE_07

// Event status: edges seen, edges on an already set flag, request rise
assign evt_set[`EIF_EVT_EDGE_LOW] = |edge_low;
assign evt_set[`EIF_EVT_EDGE_HIGH] = |edge_high;
assign evt_set[`EIF_EVT_OVR_LOW] = |(edge_low & ext_int_flag_low);
assign evt_set[`EIF_EVT_OVR_HIGH] = |(edge_high & edge_flag_bits_high);
assign evt_set[`EIF_EVT_REQ_RISE] = cpu_req_nxt & ~cpu_int_req_r;

always @*
begin
	evt_status_nxt = w1c(evt_status_r, evt_set, wr_evt_status,
		wdata_evt);
	evt_mask_nxt = evt_mask_r;
	if (wr_evt_mask)
		evt_mask_nxt = wdata_evt;
end

// Each field sits at the bottom of its byte lane; bits above it read
// as zero, which also keeps the reserved upper bits of the high
// registers at zero whatever the parameters are.
always @*
begin
	lane_flag_low = `EIF_RST_DATA;
	lane_flag_low[NLOW-1:0] = ext_int_flag_low;
	lane_en_low = `EIF_RST_DATA;
	lane_en_low[NLOW-1:0] = ext_int_enable_low_r;
	lane_flag_high = `EIF_RST_DATA;
	lane_flag_high[NHIGH-1:0] = edge_flag_bits_high;
	lane_en_high = `EIF_RST_DATA;
	lane_en_high[NHIGH-1:0] = ext_int_enable_high_r;
	lane_evt_status = `EIF_RST_DATA;
	lane_evt_status[`EIF_EVT_W-1:0] = evt_status_r;
	lane_evt_mask = `EIF_RST_DATA;
	lane_evt_mask[`EIF_EVT_W-1:0] = evt_mask_r;
	lane_pin_low = `EIF_RST_DATA;
	lane_pin_low[NLOW-1:0] = pin_level[NLOW-1:0];
	lane_pin_high = `EIF_RST_DATA;
	lane_pin_high[NHIGH-1:0] = pin_level[N-1:NLOW];
	lane_req_low = `EIF_RST_DATA;
	lane_req_low[NLOW-1:0] = req_vec[NLOW-1:0];
	lane_req_high = `EIF_RST_DATA;
	lane_req_high[NHIGH-1:0] = req_vec[N-1:NLOW];
end

// Read mux; unmapped indices and reserved bits read as zero
always @*
begin
	rdata_nxt = `EIF_RST_DATA;
	if (reg_rd)
	begin
		case (reg_addr)
			`EIF_OFS_FLAG_LOW:
				rdata_nxt = pad8(lane_flag_low, NLOW);
			`EIF_OFS_ENABLE_LOW:
				rdata_nxt = pad8(lane_en_low, NLOW);
			`EIF_OFS_FLAG_HIGH:
				rdata_nxt = pad8(lane_flag_high, NHIGH);
			`EIF_OFS_ENABLE_HIGH:
				rdata_nxt = pad8(lane_en_high, NHIGH);
			`EIF_OFS_EVT_STATUS:
				rdata_nxt = pad8(lane_evt_status, `EIF_EVT_W);
			`EIF_OFS_EVT_MASK:
				rdata_nxt = pad8(lane_evt_mask, `EIF_EVT_W);
			`EIF_OFS_PIN_LOW:
				rdata_nxt = pad8(lane_pin_low, NLOW);
			`EIF_OFS_PIN_HIGH:
				rdata_nxt = pad8(lane_pin_high, NHIGH);
			`EIF_OFS_REQ_LOW:
				rdata_nxt = pad8(lane_req_low, NLOW);
			`EIF_OFS_REQ_HIGH:
				rdata_nxt = pad8(lane_req_high, NHIGH);
			default:
				rdata_nxt = `EIF_RST_DATA;
		endcase
	end
end

// Event status and mask
always @(posedge mclk or posedge rst)
begin
	if (rst)
	begin
		evt_status_r <= `EIF_RST_EVT;
		evt_mask_r <= `EIF_RST_EVT;
	end
	else
	begin
		evt_status_r <= evt_status_nxt;
		evt_mask_r <= evt_mask_nxt;
	end
end

// Read data stands only in the cycle after the read strobe, so a
// stale value is never mistaken for an answer.
always @(posedge mclk or posedge rst)
begin
	if (rst)
		reg_rdata_r <= `EIF_RST_DATA;
	else
		reg_rdata_r <= rdata_nxt;
end

// Request outputs, one cycle behind the flag and enable registers
always @(posedge mclk or posedge rst)
begin
	if (rst)
	begin
		cpu_int_req_r <= 1'b0;
		src_req_r <= {N{1'b0}};
	end
	else
	begin
		cpu_int_req_r <= cpu_req_nxt; // RULE_05
		src_req_r <= req_vec; // RULE_05
	end
end

// Built from next-state values so the output follows status and mask
// without a further cycle of delay
always @(posedge mclk or posedge rst)
begin
	if (rst)
		irq_r <= 1'b0;
	else
		irq_r <= |(evt_status_nxt & evt_mask_nxt);
end

endmodule // eif_top

// File: test/eif_monitor.sv
// Port checker for the external interrupt flag and enable block
`timescale 1ns/100ps
module eif_monitor
#(
	parameter NLOW = 8,
	parameter NHIGH = 4
)
(
	input wire mclk,
	input wire rst,
	input wire [NLOW+NHIGH-1:0] int_pin,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_rdata_r,
	input wire cpu_int_req_r,
	input wire [NLOW+NHIGH-1:0] src_req_r,
	input wire irq_r
);
	reg [NLOW+NHIGH-1:0] pin_d_r;
	wire chg;
	// Any pin movement; only used to excuse a new request
	always @(posedge mclk or posedge rst)
		if (rst)
			pin_d_r <= '0;
		else
			pin_d_r <= int_pin;
	assign chg = pin_d_r != int_pin;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata_r == 8'h00)
		else $error("read data not zero outside read answer");
	req_any_a: assert property (cpu_int_req_r == |src_req_r)
		else $error("cpu request differs from source requests");
	rst_zero_a: assert property ($past(rst) |->
		src_req_r == '0 && !cpu_int_req_r && !irq_r)
		else $error("outputs not clear after reset");
	req_sticky_a: assert property (|($past(src_req_r) & ~src_req_r)
		|-> $past(reg_wr) || $past(reg_wr, 2))
		else $error("request dropped without a write");
	req_cause_a: assert property (|(src_req_r & ~$past(src_req_r))
		|-> $past(reg_wr) || $past(reg_wr, 2) || $past(chg, 3)
		|| $past(chg, 4) || $past(chg, 5))
		else $error("request rose without write or pin edge");
	low_off_a: assert property (reg_wr && reg_addr == 8'h05
		&& reg_wdata == 8'h00 |-> ##2 src_req_r[NLOW-1:0] == '0)
		else $error("low sources still request after disable");
	high_off_a: assert property (reg_wr && reg_addr == 8'h07
		&& reg_wdata == 8'h00 |-> ##2 src_req_r[NLOW+NHIGH-1:NLOW] == '0)
		else $error("high sources still request after disable");
	rsv_zero_a: assert property ($past(reg_rd) && ($past(reg_addr) ==
		8'h06 || $past(reg_addr) == 8'h07) |-> reg_rdata_r[7:4] == 4'h0)
		else $error("reserved bits read nonzero");
	unmap_rd_a: assert property ($past(reg_rd) && $past(reg_addr) > 8'h15
		|-> reg_rdata_r == 8'h00)
		else $error("unmapped index read nonzero");
endmodule // eif_monitor

// File: test/eif_pin_model.sv
// External interrupt sources: pins idle at their polarity level
`timescale 1ns/100ps
module eif_pin_model
(
	input wire mclk,
	output reg [11:0] pins,
	output reg [11:0] pol
);
	// Idling at the polarity level makes the first flip the active edge
	initial
	begin
		pol = 12'haaa;
		pins = 12'haaa;
	end
	// Level holds until the next flip, far longer than one clock
	task flip(input integer i);
	begin
		@(posedge mclk);
		pins[i] <= ~pins[i];
	end
	endtask
endmodule // eif_pin_model

// File: test/eif_top_tb.sv
// Self-checking bench for the external interrupt flag and enable block
`timescale 1ns/100ps
module eif_top_tb;
	reg mclk;
	reg rst;
	reg [7:0] addr;
	reg [7:0] wd;
	reg wr;
	reg rd;
	wire [7:0] rdata;
	wire req;
	wire [11:0] sreq;
	wire irq;
	wire [11:0] pins;
	wire [11:0] pol;
	reg [11:0] exp;
	integer n_mismatch;
	integer total_checks;
	integer i;
	eif_top eif_top_inst (.mclk(mclk), .rst(rst), .int_pin(pins),
		.edge_polarity_select(pol), .reg_addr(addr), .reg_wdata(wd),
		.reg_wr(wr), .reg_rd(rd), .reg_rdata_r(rdata),
		.cpu_int_req_r(req), .src_req_r(sreq), .irq_r(irq));
	eif_pin_model eif_pin_model_inst (.mclk(mclk), .pins(pins), .pol(pol));
	initial
	begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	task chk(input [11:0] got, input [11:0] want);
	begin
		total_checks = total_checks + 1;
		if (got !== want)
		begin
			n_mismatch = n_mismatch + 1;
			$display("[ERR] t=%0t got %h exp %h", $time, got, want);
		end
	end
	endtask
	task bus(input w, input r, input [7:0] a, input [7:0] d);
	begin
		@(posedge mclk);
		wr <= w;
		rd <= r;
		addr <= a;
		wd <= d;
	end
	endtask
	task wrr(input [7:0] a, input [7:0] d);
	begin
		bus(1'b1, 1'b0, a, d);
		bus(1'b0, 1'b0, a, 8'h00);
	end
	endtask
	task rdc(input [7:0] a, input [7:0] e);
	begin
		bus(1'b0, 1'b1, a, 8'h00);
		bus(1'b0, 1'b0, a, 8'h00);
		#1;
		chk({4'h0, rdata}, {4'h0, e});
	end
	endtask
	task settle(input integer n);
	begin
		repeat (n) @(posedge mclk);
		#1;
	end
	endtask
	task tally_and_finish;
	begin
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	end
	endtask
	initial
	begin
		#20000;
		n_mismatch = n_mismatch + 1;
		tally_and_finish;
	end
	initial
	begin
		n_mismatch = 0;
		total_checks = 0;
		rst = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		addr = 8'h00;
		wd = 8'h00;
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		for (i = 4; i < 8; i = i + 1)
			rdc(i, 8'h00);
		rdc(8'h20, 8'h00);
		$display("reset values done");
		wrr(8'h05, 8'ha5);
		rdc(8'h05, 8'ha5);
		wrr(8'h07, 8'hff);
		rdc(8'h07, 8'h0f);
		wrr(8'h06, 8'h01);
		settle(2);
		chk(sreq, 12'h100);
		chk({11'h000, req}, 12'h001);
		rdc(8'h15, 8'h01);
		rdc(8'h14, 8'h00);
		$display("register access done");
		wrr(8'h05, 8'hff);
		wrr(8'h06, 8'h00);
		exp = 12'h000;
		for (i = 0; i < 12; i = i + 1)
		begin
			eif_pin_model_inst.flip(i);
			exp[i] = 1'b1;
			settle(6);
			chk(sreq, exp);
		end
		rdc(8'h04, 8'hff);
		rdc(8'h06, 8'h0f);
		// Software clears serviced flags so no request follows
		wrr(8'h04, 8'h00);
		wrr(8'h06, 8'h00);
		settle(2);
		chk(sreq, 12'h000);
		for (i = 0; i < 12; i = i + 1)
			eif_pin_model_inst.flip(i);
		settle(6);
		chk(sreq, 12'h000);
		rdc(8'h12, 8'haa);
		rdc(8'h13, 8'h0a);
		$display("edge flags done");
		rdc(8'h10, 8'h13);
		chk({11'h000, irq}, 12'h000);
		wrr(8'h11, 8'h01);
		settle(2);
		chk({11'h000, irq}, 12'h001);
		wrr(8'h10, 8'h1f);
		settle(2);
		chk({11'h000, irq}, 12'h000);
		rdc(8'h10, 8'h00);
		$display("events done");
		wrr(8'h04, 8'hff);
		wrr(8'h06, 8'h0f);
		wrr(8'h05, 8'h00);
		wrr(8'h07, 8'h00);
		settle(2);
		chk(sreq, 12'h000);
		rdc(8'h04, 8'hff);
		// Selected edges on flags that are already set
		eif_pin_model_inst.flip(0);
		eif_pin_model_inst.flip(8);
		settle(6);
		rdc(8'h10, 8'h1f);
		chk({11'h000, irq}, 12'h001);
		eif_pin_model_inst.flip(0);
		eif_pin_model_inst.flip(8);
		@(posedge mclk);
		rst <= 1'b1;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		for (i = 4; i < 8; i = i + 1)
			rdc(i, 8'h00);
		rdc(8'h10, 8'h00);
		rdc(8'h11, 8'h00);
		chk({11'h000, irq}, 12'h000);
		$display("disable and reset done");
		tally_and_finish;
	end
endmodule // eif_top_tb
bind eif_top eif_monitor #(.NLOW(NLOW), .NHIGH(NHIGH)) eif_monitor_inst
	(.mclk(mclk), .rst(rst), .int_pin(int_pin), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata_r(reg_rdata_r), .cpu_int_req_r(cpu_int_req_r),
	.src_req_r(src_req_r), .irq_r(irq_r));
